// ==== hw/obl_consts.vh ====
// constants for the option bit loader and trim access block
// assumes byte-wide flash reads and a 32-bit register bus
`ifndef OBL_CONSTS_VH
`define OBL_CONSTS_VH
// ************************************
// register indices (byte address = index * 4)
// ************************************
`define OBL_IDX_TRIM_INDEX 12'hff6
`define OBL_IDX_TRIM_VALUE 12'hff7
`define OBL_IDX_PAGE_SELECT 12'hff9
`define OBL_IDX_STATUS 12'hffc
`define OBL_BYTE_ADDR(i) {18'h00000, i, 2'b00}
// ************************************
// reset values
// ************************************
`define OBL_RST_TRIM_INDEX 8'h00
`define OBL_RST_PAGE_SELECT 8'h00
`define OBL_RST_OPTION 8'hff
// ************************************
// option byte fields
// ************************************
`define OBL_BIT_WDT_ACTION 7
`define OBL_BIT_WDT_ALWAYS_ON 6
`define OBL_OSC_SEL_HI 5
`define OBL_OSC_SEL_LO 4
`define OBL_BIT_BROWNOUT_AO 3
`define OBL_BIT_READ_PROTECT 2
`define OBL_BIT_WRITE_PROTECT 0
`define OBL_BIT_XTAL_OFF 4
`define OBL_BIT_INFO_EN 7
`define OBL_BIT_STAT_BUSY 0
`define OBL_BIT_STAT_WDT_RUN 1
// ************************************
// flash locations and counts
// ************************************
`define OBL_FLASH_OPT_A 16'h0000
`define OBL_FLASH_OPT_B 16'h0001
`define OBL_FLASH_TRIM_BASE 16'h0020
`define OBL_TRIM_COUNT 6'd32
`define OBL_LOAD_LAST 6'd33
`define OBL_INFO_WIN_BASE 16'hfe00
`define OBL_RESP_OKAY 2'b00
`define OBL_RESP_SLVERR 2'b10
`endif

// ==== hw/obl_top.v ====
// option bit loader with trim index/data access over AXI4-Lite
// assumes flash data valid the cycle after FLASH_RD; cpu waits on CPU_RUN
// Functional notes
// R1 - reload options on every reset or recovery
// R2 - option changes act only after reload
// R3 - load finishes before cpu is released
// R4 - holding registers have no bus address
// R5 - option bytes at program addresses zero, one
// R6 - page zero erase gives erased defaults
// R7 - index then data write updates trim
// R8 - index then data read returns trim
// R9 - 32 trim bytes from info 20..3F
// R10 - trim writes are working copies only
// R11 - no path alters factory trim permanently
// R12 - bit 7 picks interrupt or reset
// R13 - always-on zero runs watchdog unstoppably
// R14 - always-on one starts on instruction
// R15 - two-bit oscillator mode select
// R16 - brown-out off in stop unless always-on
// R17 - read protect limits debugger when zero
// R18 - write protect blocks user program/erase
// R19 - erased all-ones bytes give defaults
// R20 - crystal runs during reset when zero
// R21 - calibration read via program load only
// R22 - serial number untouched by mass erase
// R23 - info enable maps page at FE00-FFFF
// R24 - index above 1F is ignored
// R25 - index held across data accesses
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "obl_consts.vh"
module obl_top #(
  parameter XTAL_SETTLE_CYC = 16
) (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire SYS_RESET_REQ,
  input wire STOP_RECOVERY,
  input wire STOP_MODE,
  output wire FLASH_RD,
  output wire FLASH_INFO,
  output wire [15:0] FLASH_ADDR,
  input wire [7:0] FLASH_RDATA,
  output wire CPU_RUN,
  input wire WDT_START,
  input wire WDT_TIMEOUT,
  output wire WDT_RUN,
  output wire WDT_IRQ_REQ,
  output wire WDT_SYS_RESET,
  output wire [1:0] OSC_SELECT,
  output wire BROWNOUT_EN,
  output wire DBG_FULL_ACCESS,
  output wire USER_FLASH_WR_EN,
  output wire DBG_MASS_ERASE_EN,
  output wire XTAL_EN,
  input wire [15:0] CPU_PM_ADDR,
  output wire INFO_PAGE_SEL
);
  // ************************************
  // declarations
  // ************************************
  localparam [1:0] L_ISSUE = 2'd0, L_WAIT = 2'd1, L_CAPT = 2'd2, L_SETTLE = 2'd3;
  localparam [2:0] SEL_NONE = 3'd0, SEL_INDEX = 3'd1, SEL_VALUE = 3'd2, SEL_PAGE = 3'd3;
  localparam [2:0] SEL_STAT = 3'd4;
  localparam [31:0] XTAL_CNT_FULL = XTAL_SETTLE_CYC;
  localparam [15:0] XTAL_CNT_MAX = XTAL_CNT_FULL[15:0];
  reg [1:0] lstate_q, lstate_d;
  reg [5:0] ptr_q, ptr_d;
  reg run_q, run_d, flash_rd_q, flash_rd_d, flash_info_q, flash_info_d, xtal_q, xtal_d;
  reg [15:0] settle_q, settle_d, flash_addr_q, flash_addr_d;
  reg [7:0] opt_a_q, opt_a_d, opt_b_q, opt_b_d;
  reg bo_en_q, info_sel_q, aw_q, w_q, bvalid_q, wstrb0_q, rpend_q, rvalid_q;
  reg [7:0] index_q, page_q, wbyte_q;
  reg [31:0] awaddr_q, rdata_q;
  reg [1:0] bresp_q, rresp_q;
  reg [2:0] rsel_q;
  wire restart, do_write, index_ok, bus_trim_we, ld_trim_we, mem_we;
  wire [2:0] wsel;
  wire [4:0] mem_waddr;
  wire [7:0] mem_wdata, mem_rdata;
  // single decode shared by the write and read paths
  function [2:0] reg_sel;
    input [31:0] a;
    begin
      // R4 option holding registers not decoded
      case (a)
        `OBL_BYTE_ADDR(`OBL_IDX_TRIM_INDEX): reg_sel = SEL_INDEX;
        `OBL_BYTE_ADDR(`OBL_IDX_TRIM_VALUE): reg_sel = SEL_VALUE;
        `OBL_BYTE_ADDR(`OBL_IDX_PAGE_SELECT): reg_sel = SEL_PAGE;
        `OBL_BYTE_ADDR(`OBL_IDX_STATUS): reg_sel = SEL_STAT;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // ************************************
  // option loader
  // ************************************
  // R1 reset, system reset, stop recovery reload
  assign restart = SYS_RESET_REQ || STOP_RECOVERY;
  always @* begin
    lstate_d = lstate_q;
    ptr_d = ptr_q;
    run_d = run_q;
    settle_d = settle_q;
    flash_rd_d = 1'b0;
    flash_info_d = flash_info_q;
    flash_addr_d = flash_addr_q;
    opt_a_d = opt_a_q;
    opt_b_d = opt_b_q;
    xtal_d = 1'b0;
    if (restart) begin
      lstate_d = L_ISSUE;
      ptr_d = 6'd0;
      run_d = 1'b0;
      settle_d = 16'h0000;
    end else if (!run_q) begin
      case (lstate_q)
        L_ISSUE: begin
          flash_rd_d = 1'b1;
          // R5 user bytes at program 0000, 0001
          if (ptr_q == 6'd0) begin
            flash_info_d = 1'b0;
            flash_addr_d = `OBL_FLASH_OPT_A;
          end else if (ptr_q == 6'd1) begin
            flash_info_d = 1'b0;
            flash_addr_d = `OBL_FLASH_OPT_B;
          end else begin
            // R9 trim bytes from info 20..3F
            flash_info_d = 1'b1;
            flash_addr_d = `OBL_FLASH_TRIM_BASE + {10'h000, ptr_q - 6'd2};
          end
          lstate_d = L_WAIT;
        end
        L_WAIT: begin
          lstate_d = L_CAPT;
        end
        L_CAPT: begin
          // R2 holding registers change only here
          // R6 erased flash reads ff, giving defaults
          if (ptr_q == 6'd0) begin
            opt_a_d = FLASH_RDATA;
          end else if (ptr_q == 6'd1) begin
            opt_b_d = FLASH_RDATA;
          end
          if (ptr_q == `OBL_LOAD_LAST) begin
            lstate_d = L_SETTLE;
          end else begin
            ptr_d = ptr_q + 6'd1;
            lstate_d = L_ISSUE;
          end
        end
        L_SETTLE: begin
          // R20 crystal on during reset lengthens it
          if (!opt_b_q[`OBL_BIT_XTAL_OFF] && settle_q != XTAL_CNT_MAX) begin
            xtal_d = 1'b1;
            settle_d = settle_q + 16'h0001;
          end else begin
            // R3 cpu released only after full load
            run_d = 1'b1;
          end
        end
        default: begin
          lstate_d = L_ISSUE;
        end
      endcase
    end
  end

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lstate_q <= L_ISSUE;
      ptr_q <= 6'd0;
      run_q <= 1'b0;
      settle_q <= 16'h0000;
      flash_rd_q <= 1'b0;
      flash_info_q <= 1'b0;
      flash_addr_q <= `OBL_FLASH_OPT_A;
      // R19 erased defaults until first load
      opt_a_q <= `OBL_RST_OPTION;
      opt_b_q <= `OBL_RST_OPTION;
      xtal_q <= 1'b0;
    end else begin
      lstate_q <= lstate_d;
      ptr_q <= ptr_d;
      run_q <= run_d;
      settle_q <= settle_d;
      flash_rd_q <= flash_rd_d;
      flash_info_q <= flash_info_d;
      flash_addr_q <= flash_addr_d;
      opt_a_q <= opt_a_d;
      opt_b_q <= opt_b_d;
      xtal_q <= xtal_d;
    end
  end

  // ************************************
  // trim store
  // ************************************
  // R11 flash only read here, never written
  // R22 serial bytes outside trim range, untouched
  assign ld_trim_we = !run_q && !restart && lstate_q == L_CAPT && ptr_q > 6'd1;
  // R24 out-of-range index drops the write
  assign index_ok = index_q < {2'b00, `OBL_TRIM_COUNT};
  // R7 data write goes to indexed byte
  assign bus_trim_we = do_write && wsel == SEL_VALUE && wstrb0_q && index_ok;
  // R10 reload overwrites working copies
  assign mem_we = ld_trim_we || bus_trim_we;
  assign mem_waddr = ld_trim_we ? (ptr_q[4:0] - 5'd2) : index_q[4:0];
  assign mem_wdata = ld_trim_we ? FLASH_RDATA : wbyte_q;
  obl_trim_mem #(.DEPTH_LOG2(5), .WIDTH(8)) u_mem (.clk(SYS_CLK), .we(mem_we),
    .waddr(mem_waddr), .wdata(mem_wdata), .raddr(index_q[4:0]), .rdata_q(mem_rdata));

  // ************************************
  // register write path
  // ************************************
  assign S_AXI_AWREADY = !aw_q;
  assign S_AXI_WREADY = !w_q;
  assign do_write = aw_q && w_q && !bvalid_q;
  assign wsel = reg_sel(awaddr_q);

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bresp_q <= `OBL_RESP_OKAY;
      index_q <= `OBL_RST_TRIM_INDEX;
      page_q <= `OBL_RST_PAGE_SELECT;
    end else begin
      // address and data may arrive in either order
      if (S_AXI_AWVALID && !aw_q) begin
        aw_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_q) begin
        w_q <= 1'b1;
        wbyte_q <= S_AXI_WDATA[7:0];
        wstrb0_q <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == SEL_NONE) ? `OBL_RESP_SLVERR : `OBL_RESP_OKAY;
        // R25 index changes only by its own write
        if (wsel == SEL_INDEX && wstrb0_q) begin
          index_q <= wbyte_q;
        end
        if (wsel == SEL_PAGE && wstrb0_q) begin
          page_q <= wbyte_q;
        end
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  // ************************************
  // register read path
  // ************************************
  // one wait cycle lets the store output follow a fresh index
  assign S_AXI_ARREADY = !rpend_q && !rvalid_q;

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rpend_q <= 1'b0;
      rvalid_q <= 1'b0;
      rsel_q <= SEL_NONE;
      rdata_q <= 32'h00000000;
      rresp_q <= `OBL_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rpend_q <= 1'b1;
        rsel_q <= reg_sel(S_AXI_ARADDR);
      end else if (rpend_q) begin
        rpend_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= (rsel_q == SEL_NONE) ? `OBL_RESP_SLVERR : `OBL_RESP_OKAY;
        case (rsel_q)
          SEL_INDEX: begin
            rdata_q <= {24'h000000, index_q};
          end
          SEL_VALUE: begin
            // R8 data read returns indexed byte
            // R24 bad index reads as zero
            rdata_q <= index_ok ? {24'h000000, mem_rdata} : 32'h00000000;
          end
          SEL_PAGE: begin
            rdata_q <= {24'h000000, page_q};
          end
          SEL_STAT: begin
            rdata_q <= {30'h00000000, WDT_RUN, !run_q};
          end
          default: begin
            rdata_q <= 32'h00000000;
          end
        endcase
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // ************************************
  // watchdog
  // ************************************
  obl_wdt_ctl u_wdt (.clk(SYS_CLK), .arst_n(ARST_N), .restart(restart || !run_q),
    .loaded(run_q), .always_on_n(opt_a_q[`OBL_BIT_WDT_ALWAYS_ON]),
    .action_reset(opt_a_q[`OBL_BIT_WDT_ACTION]), .start(WDT_START), .timeout(WDT_TIMEOUT),
    .run_q(WDT_RUN), .irq_q(WDT_IRQ_REQ), .sys_rst_q(WDT_SYS_RESET));
  // ************************************
  // decoded options and info window
  // ************************************
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bo_en_q <= 1'b1;
      info_sel_q <= 1'b0;
    end else begin
      // R16 brown-out off in stop unless always-on
      bo_en_q <= !(STOP_MODE && !opt_a_q[`OBL_BIT_BROWNOUT_AO]);
      // R23 info page at top of program space
      // R21 calibration reached only via this window
      info_sel_q <= page_q[`OBL_BIT_INFO_EN] && CPU_PM_ADDR >= `OBL_INFO_WIN_BASE;
    end
  end
  assign CPU_RUN = run_q;
  assign FLASH_RD = flash_rd_q;
  assign FLASH_INFO = flash_info_q;
  assign FLASH_ADDR = flash_addr_q;
  assign XTAL_EN = xtal_q;
  assign BROWNOUT_EN = bo_en_q;
  assign INFO_PAGE_SEL = info_sel_q;
  // R15 oscillator mode straight from field
  assign OSC_SELECT = opt_a_q[`OBL_OSC_SEL_HI:`OBL_OSC_SEL_LO];
  // R17 zero limits debugger access
  assign DBG_FULL_ACCESS = opt_a_q[`OBL_BIT_READ_PROTECT];
  // R18 zero blocks user program and erase
  assign USER_FLASH_WR_EN = opt_a_q[`OBL_BIT_WRITE_PROTECT];
  // debugger mass erase stays available either way
  assign DBG_MASS_ERASE_EN = 1'b1;
endmodule // obl_top

// ==== hw/obl_trim_mem.v ====
// trim working-value store, one write port, registered read
// assumes a single clock; contents undefined until first load
`timescale 1ns/1ns
module obl_trim_mem #(
  parameter DEPTH_LOG2 = 5,
  parameter WIDTH = 8
) (
  input wire clk,
  input wire we,
  input wire [DEPTH_LOG2-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [DEPTH_LOG2-1:0] raddr,
  output reg [WIDTH-1:0] rdata_q
);
  reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

  // ************************************
  // storage
  // ************************************
  // no async reset: contents are always reloaded from flash before use
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule // obl_trim_mem

// ==== hw/obl_wdt_ctl.v ====
// watchdog enable and timeout routing from the loaded option bits
// assumes timeout is a one-cycle pulse from the watchdog counter
`timescale 1ns/1ns
module obl_wdt_ctl (
  input wire clk,
  input wire arst_n,
  input wire restart,
  input wire loaded,
  input wire always_on_n,
  input wire action_reset,
  input wire start,
  input wire timeout,
  output reg run_q,
  output reg irq_q,
  output reg sys_rst_q
);
  // ************************************
  // enable
  // ************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
      irq_q <= 1'b0;
      sys_rst_q <= 1'b0;
    end else begin
      // R14 only reset or stop recovery stops
      if (restart) begin
        run_q <= 1'b0;
      // R13 always on, no way to stop
      end else if (loaded && !always_on_n) begin
        run_q <= 1'b1;
      // R14 started by instruction
      end else if (loaded && start) begin
        run_q <= 1'b1;
      end
      // R12 timeout action select
      irq_q <= timeout && run_q && !action_reset;
      sys_rst_q <= timeout && run_q && action_reset;
    end
  end
endmodule // obl_wdt_ctl

// ==== tb/obl_flash_model.sv ====
// flash array model answering the option loader's byte reads
// assumes one read per pulse and data wanted in the following cycle
`timescale 1ns/1ns
module obl_flash_model (
  input wire clk,
  input wire rd,
  input wire info,
  input wire [15:0] addr,
  output logic [7:0] rdata_q
);
  logic [7:0] opt_a_q = 8'hff;
  logic [7:0] opt_b_q = 8'hff;
  logic [7:0] trim_q [0:31];
  initial rdata_q = 8'h00;
  always @(posedge clk) begin
    if (rd && !info && addr[15:1] == 15'h0) begin
      // option bytes, erased page reads ff
      rdata_q <= addr[0] ? opt_b_q : opt_a_q;
    end else if (rd && info && addr[15:5] == 11'h001) begin
      rdata_q <= trim_q[addr[4:0]];
    end else begin
      // line released: toggle so a stale byte cannot pass
      rdata_q <= ~rdata_q;
    end
  end
endmodule // obl_flash_model

// ==== tb/obl_top_properties.sv ====
// port checker for the option loader top
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ns
module obl_top_properties (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire SYS_RESET_REQ,
  input wire STOP_RECOVERY,
  input wire STOP_MODE,
  input wire FLASH_RD,
  input wire FLASH_INFO,
  input wire [15:0] FLASH_ADDR,
  input wire CPU_RUN,
  input wire WDT_TIMEOUT,
  input wire WDT_RUN,
  input wire WDT_IRQ_REQ,
  input wire WDT_SYS_RESET,
  input wire BROWNOUT_EN,
  input wire DBG_MASS_ERASE_EN,
  input wire XTAL_EN,
  input wire [15:0] CPU_PM_ADDR,
  input wire INFO_PAGE_SEL
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // ************************************
  // assertions
  // ************************************
  cpu_hold_a: assert property (FLASH_RD |-> !CPU_RUN)
    else $error("cpu released during option load");
  restart_drop_a: assert property (SYS_RESET_REQ || STOP_RECOVERY |=> !CPU_RUN && !WDT_RUN)
    else $error("restart did not halt cpu and watchdog");
  opt_addr_a: assert property (FLASH_RD && !FLASH_INFO |-> FLASH_ADDR[15:1] == 15'h0000)
    else $error("option fetch outside bytes zero and one");
  trim_addr_a: assert property (FLASH_RD && FLASH_INFO |-> FLASH_ADDR[15:5] == 11'h001)
    else $error("trim fetch outside info 20..3f");
  rd_space_a: assert property (FLASH_RD |=> !FLASH_RD [*2])
    else $error("flash reads closer than three cycles");
  wdt_resp_a: assert property (WDT_IRQ_REQ || WDT_SYS_RESET |->
    $past(WDT_TIMEOUT) && $past(WDT_RUN) && !(WDT_IRQ_REQ && WDT_SYS_RESET))
    else $error("watchdog response without timeout");
  wdt_keep_a: assert property (WDT_RUN && !SYS_RESET_REQ && !STOP_RECOVERY |=> WDT_RUN)
    else $error("watchdog stopped without reset");
  brownout_on_a: assert property ($past(STOP_MODE) == 1'b0 |-> BROWNOUT_EN)
    else $error("brownout off outside stop");
  xtal_reset_a: assert property (XTAL_EN |-> !CPU_RUN)
    else $error("crystal settle after cpu release");
  info_map_a: assert property (INFO_PAGE_SEL |-> $past(CPU_PM_ADDR[15:9]) == 7'h7f)
    else $error("info page selected below fe00");
  dbg_erase_a: assert property (DBG_MASS_ERASE_EN)
    else $error("debugger mass erase blocked");
  load_done_c: cover property ($rose(CPU_RUN));
  irq_c: cover property (WDT_IRQ_REQ);
  wdt_rst_c: cover property (WDT_SYS_RESET);
  xtal_c: cover property (XTAL_EN);
endmodule // obl_top_properties

// ==== tb/option_bit_loader_trim_access_tb.sv ====
// self-checking bench for the option loader and trim access
// assumes the flash model answers the cycle after each read pulse
`timescale 1ns/1ns
module option_bit_loader_trim_access_tb;
  localparam logic [31:0] A_IDX = 32'h00003fd8;
  localparam logic [31:0] A_VAL = 32'h00003fdc;
  localparam logic [31:0] A_PSEL = 32'h00003fe4;
  localparam logic [31:0] A_STAT = 32'h00003ff0;
  localparam int XCYC = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic stop_mode = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [3:0] ctl = 4'h0;
  logic [15:0] pm_addr = 16'h0000;
  logic [7:0] shadow [0:31];
  logic [7:0] v;
  logic [15:0] a16;
  wire awready, wready, bvalid, arready, rvalid, frd, finfo, cpu_run, wdt_run, wdt_irq;
  wire wdt_rst, bo_en, dbg_full, user_wr, xtal_en, info_sel;
  wire [1:0] bresp, rresp, osc;
  wire [31:0] rdata;
  wire [15:0] faddr;
  wire [7:0] fdata;
  int err_count = 0;
  int comparisons = 0;
  logic [1:0] bq [$];
  logic [33:0] rq [$];
  always #20 clk = ~clk;
  obl_top #(.XTAL_SETTLE_CYC(XCYC)) obl_top_inst (.SYS_CLK(clk), .ARST_N(arst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SYS_RESET_REQ(ctl[3]), .STOP_RECOVERY(ctl[2]), .STOP_MODE(stop_mode),
    .FLASH_RD(frd), .FLASH_INFO(finfo), .FLASH_ADDR(faddr), .FLASH_RDATA(fdata),
    .CPU_RUN(cpu_run), .WDT_START(ctl[1]), .WDT_TIMEOUT(ctl[0]), .WDT_RUN(wdt_run),
    .WDT_IRQ_REQ(wdt_irq), .WDT_SYS_RESET(wdt_rst), .OSC_SELECT(osc), .BROWNOUT_EN(bo_en),
    .DBG_FULL_ACCESS(dbg_full), .USER_FLASH_WR_EN(user_wr), .DBG_MASS_ERASE_EN(),
    .XTAL_EN(xtal_en), .CPU_PM_ADDR(pm_addr), .INFO_PAGE_SEL(info_sel));
  obl_flash_model obl_flash_model_inst (.clk(clk), .rd(frd), .info(finfo), .addr(faddr),
    .rdata_q(fdata));
  // ************************************
  // checking and closing
  // ************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // responses are judged when they appear, in order of issue
  always @(posedge clk) begin
    if (bvalid && bready) chk(32'(bresp), 32'(bq.pop_front()));
    if (rvalid && rready) begin
      chk(rdata, rq[0][33:2]);
      chk(32'(rresp), 32'(rq[0][1:0]));
      void'(rq.pop_front());
    end
  end
  // ************************************
  // bus and pin tasks
  // ************************************
  task automatic xfer(input bit w, input logic [31:0] a, input logic [7:0] d,
      input logic [7:0] e, input logic [1:0] r);
    int n;
    bit ta, tw, tr, td;
    if (w) bq.push_back(r);
    else rq.push_back({24'h0, e, r});
    @(posedge clk);
    if (w) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    n = 0;
    td = 1'b0;
    while (!td && n < 300) begin
      @(negedge clk);
      n++;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      td = (bready && bvalid) || (rready && rvalid);
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (td) bready <= 1'b0;
      if (td) rready <= 1'b0;
    end
    if (!td) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 8'h00, 2'b00);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, e, 2'b00);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ctl <= m;
    @(posedge clk);
    ctl <= 4'h0;
    @(negedge clk);
  endtask
  // bounded wait for cpu release, counting crystal settle cycles
  task automatic wait_run(input int ex);
    int n, x;
    n = 0;
    x = 0;
    do begin
      @(negedge clk);
      n++;
      x += (xtal_en === 1'b1);
    end while (cpu_run !== 1'b1 && n < 1000);
    if (cpu_run !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    chk(32'(x), 32'(ex));
  endtask
  task automatic outs(input logic [5:0] e);
    chk({26'h0, osc, bo_en, dbg_full, user_wr, wdt_run}, {26'h0, e});
  endtask
  task automatic probe(input logic [15:0] a, input logic e);
    @(posedge clk);
    pm_addr <= a;
    repeat (2) @(negedge clk);
    chk(32'(info_sel), 32'(e));
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    void'($urandom(32'hcc30081f));
    for (int i = 0; i < 32; i++) begin
      shadow[i] = 8'($urandom);
      obl_flash_model_inst.trim_q[i] = shadow[i];
    end
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    wait_run(0);
    outs(6'b111110);
    rd(A_IDX, 8'h00);
    rd(A_STAT, 8'h00);
    for (int i = 0; i < 32; i++) begin
      v = 8'($urandom);
      wr(A_IDX, 8'(i));
      rd(A_VAL, shadow[i]);
      wr(A_VAL, v);
      rd(A_VAL, v);
    end
    wr(A_IDX, 8'h20);
    wr(A_VAL, 8'h5a);
    rd(A_VAL, 8'h00);
    rd(A_IDX, 8'h20);
    // strobe bit zero low: index must not move
    @(posedge clk);
    wstrb <= 4'he;
    wr(A_IDX, 8'h05);
    wstrb <= 4'hf;
    rd(A_IDX, 8'h20);
    // unmapped places: holding registers have no address
    xfer(1'b0, 32'h0, 8'h00, 8'h00, 2'b10);
    xfer(1'b1, 32'h4, 8'h12, 8'h00, 2'b10);
    wr(A_PSEL, 8'h80);
    rd(A_PSEL, 8'h80);
    probe(16'hfe00, 1'b1);
    probe(16'hfdff, 1'b0);
    // calibration bytes reached through the program window
    probe(16'hfe60, 1'b1);
    for (int i = 0; i < 4; i++) begin
      a16 = 16'($urandom);
      probe(a16, a16[15:9] == 7'h7f);
    end
    obl_flash_model_inst.opt_a_q = 8'h22;
    obl_flash_model_inst.opt_b_q = 8'hef;
    repeat (3) @(negedge clk);
    outs(6'b111110);
    pulse(4'h8);
    wait_run(XCYC);
    repeat (2) @(negedge clk);
    outs(6'b101001);
    wr(A_IDX, 8'h00);
    rd(A_VAL, shadow[0]);
    @(posedge clk);
    stop_mode <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(bo_en), 32'h0);
    @(posedge clk);
    stop_mode <= 1'b0;
    pulse(4'h1);
    chk({30'h0, wdt_irq, wdt_rst}, 32'h2);
    obl_flash_model_inst.opt_a_q = 8'hff;
    obl_flash_model_inst.opt_b_q = 8'hff;
    pulse(4'h4);
    wait_run(0);
    repeat (2) @(negedge clk);
    outs(6'b111110);
    pulse(4'h1);
    chk({30'h0, wdt_irq, wdt_rst}, 32'h0);
    pulse(4'h2);
    chk(32'(wdt_run), 32'h1);
    pulse(4'h1);
    chk({30'h0, wdt_irq, wdt_rst}, 32'h1);
    wrap_up();
  end
endmodule // option_bit_loader_trim_access_tb
bind obl_top obl_top_properties obl_top_properties_inst (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
  .SYS_RESET_REQ(SYS_RESET_REQ), .STOP_RECOVERY(STOP_RECOVERY), .STOP_MODE(STOP_MODE),
  .FLASH_RD(FLASH_RD), .FLASH_INFO(FLASH_INFO), .FLASH_ADDR(FLASH_ADDR), .CPU_RUN(CPU_RUN),
  .WDT_TIMEOUT(WDT_TIMEOUT), .WDT_RUN(WDT_RUN), .WDT_IRQ_REQ(WDT_IRQ_REQ),
  .WDT_SYS_RESET(WDT_SYS_RESET), .BROWNOUT_EN(BROWNOUT_EN),
  .DBG_MASS_ERASE_EN(DBG_MASS_ERASE_EN), .XTAL_EN(XTAL_EN), .CPU_PM_ADDR(CPU_PM_ADDR),
  .INFO_PAGE_SEL(INFO_PAGE_SEL));
